// *** rtl/fetch_sequencer.sv ***
// Fetch sequencer end: AXI4-Lite orders in, instructions out
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module fetch_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  trace_link_if.sequencer link
);

  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q, rdata_q, fetch_q;
  logic [63:0] instr_q;
  logic issue_q, target_we_q, seed_we_q, slot_q;
  logic [31:0] target_q, seed_data_q;
  logic [4:0] seed_addr_q;
  logic do_write, refuse;
  logic [3:0] wstrb_q;

  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  // Flow change in a delay slot, or an odd target, is refused
  assign refuse = ((waddr_q == trace_pkg::REG_ISSUE) && slot_q &&
                   (instr_q[trace_pkg::FLOW_HI:trace_pkg::FLOW_LO] !=
                    trace_pkg::FLOW_NOP)) ||
                  ((waddr_q == trace_pkg::REG_TARGET) && wdata_q[0]);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= trace_pkg::REG_STATUS) && (a[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channels

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= trace_pkg::WORD_ZERO;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= trace_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        // Strobes travel with their data word
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (!mapped(waddr_q) || refuse) ?
                   trace_pkg::RESP_SLVERR : trace_pkg::RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and link strobes

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_q <= 64'h0;
      issue_q <= 1'b0;
      target_we_q <= 1'b0;
      target_q <= trace_pkg::WORD_ZERO;
      seed_we_q <= 1'b0;
      seed_addr_q <= trace_pkg::SADDR_RST;
      seed_data_q <= trace_pkg::WORD_ZERO;
    end else if (ce) begin
      issue_q <= do_write && !refuse && (waddr_q == trace_pkg::REG_ISSUE);
      target_we_q <= do_write && !refuse &&
                     (waddr_q == trace_pkg::REG_TARGET);
      seed_we_q <= do_write && (wstrb_q == 4'hf) &&
                   (waddr_q == trace_pkg::REG_SEED_DATA);
      // A refused write leaves every register as it was
      if (do_write && !refuse && wstrb_q == 4'hf) begin
        unique case (waddr_q)
          trace_pkg::REG_INSTR_LO: instr_q[31:0] <= wdata_q;
          trace_pkg::REG_INSTR_HI: instr_q[63:32] <= wdata_q;
          trace_pkg::REG_TARGET: target_q <= wdata_q;
          trace_pkg::REG_SEED_ADDR: seed_addr_q <= wdata_q[4:0];
          trace_pkg::REG_SEED_DATA: seed_data_q <= wdata_q;
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_q <= 1'b0;
      fetch_q <= trace_pkg::ADDR_RST;
    end else if (ce) begin
      if (issue_q) begin
        slot_q <= (instr_q[trace_pkg::FLOW_HI:trace_pkg::FLOW_LO] !=
                   trace_pkg::FLOW_NOP);
      end
      if (link.fetch_valid) begin
        fetch_q <= link.fetch_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= trace_pkg::WORD_ZERO;
      rresp_q <= trace_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= mapped(s_axi_araddr) ?
                   trace_pkg::RESP_OKAY : trace_pkg::RESP_SLVERR;
        rdata_q <= trace_pkg::WORD_ZERO;
        unique case (s_axi_araddr)
          trace_pkg::REG_INSTR_LO: rdata_q <= instr_q[31:0];
          trace_pkg::REG_INSTR_HI: rdata_q <= instr_q[63:32];
          trace_pkg::REG_TARGET: rdata_q <= target_q;
          trace_pkg::REG_SEED_ADDR: rdata_q <= {27'h0, seed_addr_q};
          trace_pkg::REG_SEED_DATA: rdata_q <= seed_data_q;
          trace_pkg::REG_FETCH: rdata_q <= fetch_q;
          trace_pkg::REG_STATUS: begin
            rdata_q[trace_pkg::STAT_FLAGS_LO +: 8] <= link.wrap_flags;
            rdata_q[trace_pkg::STAT_IDX_LO +: 3] <= link.ptr_index;
            rdata_q[trace_pkg::STAT_SLOT] <= slot_q;
          end
          default: begin
          end
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign link.instr_valid = issue_q;
  assign link.instr = instr_q;
  assign link.target_we = target_we_q;
  assign link.target_data = target_q;
  assign link.seed_we = seed_we_q;
  assign link.seed_addr = seed_addr_q;
  assign link.seed_data = seed_data_q;

endmodule // fetch_sequencer
`default_nettype wire

// *** rtl/repeat_counter_branch_unit.sv ***
// Repetition counters, seed memory and flow change unit
`timescale 1ns/100ps
`default_nettype none
module repeat_counter_branch_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  trace_link_if.device link,
  output logic save_done,
  output logic [2:0] save_slot
);

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  logic issue;
  logic [2:0] flow_op;
  logic [2:0] flag_sel;
  logic [2:0] cnt_op;
  logic [trace_pkg::SEED_AW-1:0] seed_sel;
  logic [2:0] cnt_sel;
  logic cond_taken;

  assign issue = link.instr_valid;
  assign flow_op = link.instr[trace_pkg::FLOW_HI:trace_pkg::FLOW_LO];
  assign flag_sel = link.instr[trace_pkg::FSEL_HI:trace_pkg::FSEL_LO];
  assign cnt_op = link.instr[trace_pkg::COP_HI:trace_pkg::COP_LO];
  assign seed_sel = link.instr[trace_pkg::SADDR_HI:trace_pkg::SADDR_LO];
  assign cnt_sel = link.instr[trace_pkg::CNUM_HI:trace_pkg::CNUM_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  // Entry 0 is the branch target register, 1 to 7 the pointer stack
  logic [trace_pkg::ADDR_W-1:0] ptr_q [trace_pkg::NUM_PTR];
  logic [trace_pkg::IDX_W-1:0] idx_q;
  logic [trace_pkg::ADDR_W-1:0] fetch_addr_q;
  logic fetch_valid_q;

  logic [trace_pkg::CNT_W-1:0] cnt_q [trace_pkg::NUM_CNT];
  logic [trace_pkg::NUM_CNT-1:0] wrap_q;

  logic [trace_pkg::CNT_W-1:0] seed_q [trace_pkg::SEED_DEPTH];

  logic [trace_pkg::SEED_AW-1:0] prev_saddr_q;
  logic save_pend_q;
  logic [trace_pkg::SEED_AW-1:0] save_addr_q;
  logic save_done_q;
  logic [2:0] save_slot_q;

  logic [trace_pkg::ADDR_W-1:0] target;
  logic [trace_pkg::IDX_W-1:0] idx_up;
  logic [trace_pkg::IDX_W-1:0] idx_down;

  assign target = ptr_q[trace_pkg::BT_IDX];
  assign idx_up = idx_q + trace_pkg::IDX_ONE;
  assign idx_down = idx_q - trace_pkg::IDX_ONE;
  assign cond_taken = wrap_q[flag_sel];

  ////////////////////////////////////////////////////////////////////////////
  // Flow change unit

  // The instruction now issued was fetched one step earlier, so the
  // address chosen here is used after exactly one delay slot.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < trace_pkg::NUM_PTR; i++) begin
        ptr_q[i] <= trace_pkg::ADDR_RST;
      end
      idx_q <= trace_pkg::FIRST_IDX;
      fetch_addr_q <= trace_pkg::ADDR_RST;
      fetch_valid_q <= 1'b0;
    end else if (ce) begin
      fetch_valid_q <= issue;
      if (link.target_we) begin
        ptr_q[trace_pkg::BT_IDX] <= link.target_data;
      end
      if (issue) begin
        unique case (flow_op)
          trace_pkg::FLOW_CALL: begin
            fetch_addr_q <= target;
            ptr_q[idx_up] <= target + trace_pkg::ADDR_ONE;
            idx_q <= idx_up;
          end
          trace_pkg::FLOW_JUMP: begin
            fetch_addr_q <= target;
            ptr_q[idx_q] <= target + trace_pkg::ADDR_ONE;
          end
          trace_pkg::FLOW_COND: begin
            if (cond_taken) begin
              fetch_addr_q <= target;
              ptr_q[idx_q] <= target + trace_pkg::ADDR_ONE;
            end else begin
              fetch_addr_q <= ptr_q[idx_q];
              ptr_q[idx_q] <= ptr_q[idx_q] + trace_pkg::ADDR_ONE;
            end
          end
          trace_pkg::FLOW_RET: begin
            fetch_addr_q <= ptr_q[idx_down];
            ptr_q[idx_down] <= ptr_q[idx_down] + trace_pkg::ADDR_ONE;
            idx_q <= idx_down;
          end
          default: begin
            // No change of control, including the unused codes
            fetch_addr_q <= ptr_q[idx_q];
            ptr_q[idx_q] <= ptr_q[idx_q] + trace_pkg::ADDR_ONE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < trace_pkg::NUM_CNT; i++) begin
        cnt_q[i] <= trace_pkg::CNT_RST;
      end
      wrap_q <= '0;
    end else if (ce && issue) begin
      unique case (cnt_op)
        trace_pkg::CNT_FETCH: begin
          cnt_q[cnt_sel] <= seed_q[seed_sel];
          wrap_q[cnt_sel] <= 1'b0;
        end
        trace_pkg::CNT_STEP: begin
          // Natural 32-bit wrap takes the count to zero
          cnt_q[cnt_sel] <= cnt_q[cnt_sel] + trace_pkg::CNT_ONE;
          if (cnt_q[cnt_sel] == trace_pkg::CNT_MAX) begin
            wrap_q[cnt_sel] <= 1'b1;
          end
        end
        default: begin
          // Idle and save leave the counters alone
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Save pipeline

  // Each issued instruction offers its address field to a save that may
  // follow; a pending save takes its counter number from the next issue.
  // The overlap of two saves falls out of this with no extra state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_saddr_q <= trace_pkg::SADDR_RST;
      save_pend_q <= 1'b0;
      save_addr_q <= trace_pkg::SADDR_RST;
    end else if (ce && issue) begin
      prev_saddr_q <= seed_sel;
      save_pend_q <= (cnt_op == trace_pkg::CNT_SAVE);
      save_addr_q <= prev_saddr_q;
    end
  end

  // Pipeline write wins over a seed load in the same cycle; it reads the
  // count before any update of this cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < trace_pkg::SEED_DEPTH; i++) begin
        seed_q[i] <= trace_pkg::CNT_RST;
      end
    end else if (ce) begin
      if (issue && save_pend_q) begin
        seed_q[save_addr_q] <= cnt_q[cnt_sel];
      end else if (link.seed_we) begin
        seed_q[link.seed_addr] <= link.seed_data;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      save_done_q <= 1'b0;
      save_slot_q <= 3'h0;
    end else if (ce) begin
      save_done_q <= issue && save_pend_q;
      if (issue && save_pend_q) begin
        save_slot_q <= cnt_sel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign link.fetch_valid = fetch_valid_q;
  assign link.fetch_addr = fetch_addr_q;
  assign link.ptr_index = idx_q;
  assign link.wrap_flags = wrap_q;
  assign save_done = save_done_q;
  assign save_slot = save_slot_q;

endmodule // repeat_counter_branch_unit
`default_nettype wire

// *** rtl/trace_link_if.sv ***
// Link between the fetch sequencer and the counter/flow unit
`timescale 1ns/100ps
`default_nettype none
interface trace_link_if;
  logic instr_valid;
  logic [63:0] instr;
  logic target_we;
  logic [31:0] target_data;
  logic seed_we;
  logic [4:0] seed_addr;
  logic [31:0] seed_data;
  logic fetch_valid;
  logic [31:0] fetch_addr;
  logic [2:0] ptr_index;
  logic [7:0] wrap_flags;
  modport device (
    input instr_valid, instr, target_we, target_data,
    input seed_we, seed_addr, seed_data,
    output fetch_valid, fetch_addr, ptr_index, wrap_flags
  );
  modport sequencer (
    output instr_valid, instr, target_we, target_data,
    output seed_we, seed_addr, seed_data,
    input fetch_valid, fetch_addr, ptr_index, wrap_flags
  );
endinterface
`default_nettype wire

// *** rtl/trace_pkg.sv ***
// Shared constants for the repeat counter and flow change unit
// Function
// - subroutine_enter jumps, pushes pointer, raises index
// - One delay slot, then next higher pointer
// - Program loads branch target before subroutine_enter
// - No flow change inside a delay slot
// - Flow changes and targets on even addresses
// - branch_op fetches target, rewrites current pointer
// - conditional_branch branches only if wrap flag set
// - Flag select field bits 39..37, values 0-7
// - Eight 32-bit counters, each with wrap flag
// - Seed memory 32 bits wide, 32 deep
// - Overflow on increment sets the wrap flag
// - Seed equals maximum minus repetitions plus one
// - Seeds written in slow mode beforehand
// - Counter field: opcode, seed address, counter number
// - counter_idle_op does nothing
// - counter_fetch_op loads counter from seed memory
// - count_step adds one to selected counter
// - counter_save_op: address before, counter after
// - Two back-to-back saves overlap in five
// - Index 0 is branch target, 1-7 pointers
// - Opcode 000 no change; 010 returns downward
package trace_pkg;
  localparam int INSTR_W = 64;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 32;
  localparam int NUM_CNT = 8;
  localparam int SEED_DEPTH = 32;
  localparam int SEED_AW = 5;
  localparam int NUM_PTR = 8;
  localparam int IDX_W = 3;
  localparam int FLOW_HI = 50;
  localparam int FLOW_LO = 48;
  localparam int FSEL_HI = 39;
  localparam int FSEL_LO = 37;
  localparam int COP_HI = 36;
  localparam int COP_LO = 34;
  localparam int SADDR_HI = 33;
  localparam int SADDR_LO = 29;
  localparam int CNUM_HI = 28;
  localparam int CNUM_LO = 26;
  localparam logic [2:0] FLOW_NOP = 3'h0;
  localparam logic [2:0] FLOW_RET = 3'h2;
  localparam logic [2:0] FLOW_CALL = 3'h3;
  localparam logic [2:0] FLOW_COND = 3'h4;
  localparam logic [2:0] FLOW_JUMP = 3'h5;
  localparam logic [2:0] CNT_IDLE = 3'h0;
  localparam logic [2:0] CNT_FETCH = 3'h2;
  localparam logic [2:0] CNT_STEP = 3'h3;
  localparam logic [2:0] CNT_SAVE = 3'h5;
  localparam logic [IDX_W-1:0] BT_IDX = 3'h0;
  localparam logic [IDX_W-1:0] FIRST_IDX = 3'h1;
  localparam logic [IDX_W-1:0] IDX_ONE = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 32'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h1;
  localparam logic [CNT_W-1:0] CNT_MAX = 32'hffffffff;
  localparam logic [SEED_AW-1:0] SADDR_RST = 5'h0;
  // Register map of the sequencer slave
  localparam logic [7:0] REG_INSTR_LO = 8'h00;
  localparam logic [7:0] REG_INSTR_HI = 8'h04;
  localparam logic [7:0] REG_ISSUE = 8'h08;
  localparam logic [7:0] REG_TARGET = 8'h0c;
  localparam logic [7:0] REG_SEED_ADDR = 8'h10;
  localparam logic [7:0] REG_SEED_DATA = 8'h14;
  localparam logic [7:0] REG_FETCH = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam int STAT_FLAGS_LO = 0;
  localparam int STAT_IDX_LO = 8;
  localparam int STAT_SLOT = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0;
endpackage

// *** tb/repeat_counter_branch_unit_asserts.sv ***
// Link checker for the counter and flow change unit
`timescale 1ns/100ps
`default_nettype none
module repeat_counter_branch_unit_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic [63:0] instr,
  input wire logic target_we,
  input wire logic [31:0] target_data,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic [2:0] ptr_index,
  input wire logic [7:0] wrap_flags
);
  logic [31:0] target_q;
  logic go;
  logic [2:0] fl;
  logic [2:0] co;
  assign go = ce && instr_valid;
  assign fl = instr[50:48];
  assign co = instr[36:34];
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the branch target, old value wins over a same-cycle load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_q <= 32'h0;
    end else if (ce && target_we) begin
      target_q <= target_data;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  AST_FETCH_ONLY: assert property (fetch_valid == $past(go))
    else $error("fetch pulse not tied to an issue");
  AST_CALL: assert property (go && fl == 3'h3 |=>
    fetch_addr == $past(target_q) && ptr_index == $past(ptr_index) + 3'h1)
    else $error("call fetch or index wrong");
  AST_JUMP: assert property (go && fl == 3'h5 |=>
    fetch_addr == $past(target_q) && $stable(ptr_index))
    else $error("jump fetch wrong");
  AST_COND_TAKEN: assert property (go && fl == 3'h4
    && wrap_flags[instr[39:37]] |=> fetch_addr == $past(target_q))
    else $error("taken conditional branch fetch wrong");
  AST_COND_IDX: assert property (go && fl == 3'h4 |=> $stable(ptr_index))
    else $error("conditional branch moved the index");
  AST_RET: assert property (go && fl == 3'h2 |=>
    ptr_index == $past(ptr_index) - 3'h1)
    else $error("return index wrong");
  AST_LOAD_CLEARS: assert property (go && co == 3'h2 |=>
    !wrap_flags[$past(instr[28:26])])
    else $error("load left wrap flag set");
  AST_STICKY: assert property (!(go && co == 3'h2) |=>
    (wrap_flags & $past(wrap_flags)) == $past(wrap_flags))
    else $error("wrap flag dropped without a load");
  AST_IDLE: assert property (go && co == 3'h0 |=> $stable(wrap_flags))
    else $error("idle counter op changed flags");
  AST_QUIET: assert property (!go |=> $stable(wrap_flags))
    else $error("flags changed without an issue");
  cover property (go && fl == 3'h3);
  cover property (go && fl == 3'h4 && wrap_flags[instr[39:37]]);
  cover property (go && co == 3'h5);
endmodule // repeat_counter_branch_unit_asserts
`default_nettype wire

// *** tb/repeat_counter_branch_unit_tb.sv ***
// Testbench: AXI4-Lite orders through the sequencer into the unit
`timescale 1ns/100ps
`default_nettype none
module repeat_counter_branch_unit_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, save_done;
  logic [1:0] bresp, rresp, resp_q;
  logic [31:0] rdata, rd_q;
  logic [2:0] save_slot;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int saves_seen = 0;
  trace_link_if link ();
  fetch_sequencer u_fetch_sequencer (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link)
  );
  repeat_counter_branch_unit u_repeat_counter_branch_unit (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .link(link),
    .save_done(save_done), .save_slot(save_slot)
  );
  repeat_counter_branch_unit_asserts u_repeat_counter_branch_unit_asserts (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .instr_valid(link.instr_valid),
    .instr(link.instr), .target_we(link.target_we),
    .target_data(link.target_data), .fetch_valid(link.fetch_valid),
    .fetch_addr(link.fetch_addr), .ptr_index(link.ptr_index),
    .wrap_flags(link.wrap_flags)
  );
  ////////////////////////////////////////////////////////////////////////////
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("ERROR t=%0t timeout", $time);
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Counts save pulses from the unit
  always @(posedge aclk) begin
    if (save_done) begin
      saves_seen++;
    end
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t resp %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp_q = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd_q = rdata;
    resp_q = rresp;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d);
    chk_resp(resp_q, 2'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a);
    chk_word(rd_q, exp);
  endtask
  // Status with the delay-slot bit masked off
  task automatic st(input logic [2:0] idx, input logic [7:0] flags);
    axi_rd(8'h1c);
    chk_word(rd_q & 32'h7ff, {21'h0, idx, flags});
  endtask
  task automatic iss(input logic [2:0] f, input logic [2:0] z,
      input logic [2:0] c, input logic [4:0] a, input logic [2:0] n);
    logic [63:0] i;
    i = 64'h0;
    i[50:48] = f;
    i[39:37] = z;
    i[36:26] = {c, a, n};
    wr(8'h00, i[31:0]);
    wr(8'h04, i[63:32]);
    wr(8'h08, 32'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    st(3'h1, 8'h00);
    rd(8'h18, 32'h0);
    axi_rd(8'h20);
    chk_resp(resp_q, 2'h2);
    axi_wr(8'h0c, 32'h101);
    chk_resp(resp_q, 2'h2);
    rd(8'h0c, 32'h0);
    wr(8'h0c, 32'h100);
    wr(8'h10, 32'h3);
    wr(8'h14, 32'hfffffffe);
    wr(8'h10, 32'h4);
    wr(8'h14, 32'hffffffff);
    $display("test reset_and_setup done");
    iss(3'h0, 3'h0, 3'h2, 5'h3, 3'h5);
    iss(3'h0, 3'h0, 3'h3, 5'h1f, 3'h5);
    st(3'h1, 8'h00);
    iss(3'h0, 3'h0, 3'h3, 5'h0, 3'h5);
    st(3'h1, 8'h20);
    iss(3'h0, 3'h0, 3'h0, 5'h3, 3'h5);
    iss(3'h0, 3'h0, 3'h3, 5'h0, 3'h5);
    st(3'h1, 8'h20);
    iss(3'h4, 3'h4, 3'h0, 5'h0, 3'h0);
    rd(8'h18, 32'h5);
    iss(3'h0, 3'h0, 3'h0, 5'h0, 3'h0);
    for (int k = 0; k < 8; k++) begin
      iss(3'h0, 3'h0, 3'h2, 5'h4, 3'(k));
      iss(3'h0, 3'h0, 3'h3, 5'h0, 3'(k));
      iss(3'h4, 3'(k), 3'h0, 5'h0, 3'h0);
      rd(8'h18, 32'h100);
      iss(3'h0, 3'h0, 3'h0, 5'h0, 3'h0);
    end
    st(3'h1, 8'hff);
    $display("test counters_and_cond done");
    wr(8'h0c, 32'h200);
    iss(3'h3, 3'h0, 3'h0, 5'h0, 3'h0);
    st(3'h2, 8'hff);
    rd(8'h18, 32'h200);
    iss(3'h0, 3'h0, 3'h0, 5'h0, 3'h0);
    rd(8'h18, 32'h201);
    iss(3'h2, 3'h0, 3'h0, 5'h0, 3'h0);
    rd(8'h18, 32'h102);
    iss(3'h0, 3'h0, 3'h0, 5'h0, 3'h0);
    iss(3'h5, 3'h0, 3'h0, 5'h0, 3'h0);
    axi_wr(8'h08, 32'h0);
    chk_resp(resp_q, 2'h2);
    iss(3'h0, 3'h0, 3'h0, 5'h0, 3'h0);
    rd(8'h18, 32'h201);
    st(3'h1, 8'hff);
    $display("test call_ret_jump done");
    iss(3'h0, 3'h0, 3'h2, 5'h4, 3'h2);
    iss(3'h0, 3'h0, 3'h2, 5'h3, 3'h3);
    iss(3'h0, 3'h0, 3'h0, 5'h9, 3'h0);
    iss(3'h0, 3'h0, 3'h5, 5'h0, 3'h0);
    iss(3'h0, 3'h0, 3'h0, 5'ha, 3'h2);
    iss(3'h0, 3'h0, 3'h5, 5'h0, 3'h0);
    iss(3'h0, 3'h0, 3'h0, 5'h0, 3'h3);
    @(posedge aclk);
    chk_word({29'h0, save_slot}, 32'h3);
    iss(3'h0, 3'h0, 3'h2, 5'h9, 3'h6);
    iss(3'h0, 3'h0, 3'h3, 5'h0, 3'h6);
    iss(3'h0, 3'h0, 3'h2, 5'ha, 3'h7);
    iss(3'h0, 3'h0, 3'h3, 5'h0, 3'h7);
    st(3'h1, 8'h73);
    iss(3'h0, 3'h0, 3'h3, 5'h0, 3'h7);
    st(3'h1, 8'hf3);
    chk_word(32'(saves_seen), 32'h2);
    $display("test counter_saves done");
    finish_test();
  end
endmodule // repeat_counter_branch_unit_tb
`default_nettype wire
